/* File: cpu_bus_model.sv */
// cpu side of the 8-bit peripheral bus with byte access tasks
`timescale 1ns/1ps
module cpu_bus_model
  import timer_f_pkg::*;
(
  // clock
  input  wire logic              mclk_in,
  // bus towards the timer
  output logic      [ADDR_W-1:0] bus_addr_out,
  output logic                   bus_wr_out,
  output logic                   bus_rd_out,
  output logic      [DATA_W-1:0] bus_wdata_out,
  input  wire logic [DATA_W-1:0] bus_rdata_in
);
  // idle bus from time zero
  initial begin
    bus_addr_out = 3'h7;
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_wdata_out = 8'h00;
  end

  // one byte: raised after an edge, taken at the next, dropped there
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge mclk_in);
    bus_wr_out <= w;
    bus_rd_out <= !w;
    bus_addr_out <= a;
    bus_wdata_out <= d;
    @(posedge mclk_in);
    bus_wr_out <= 1'b0;
    bus_rd_out <= 1'b0;
    bus_wdata_out <= ~d; // stale data must not look valid
    #1;
    q = bus_rdata_in;
  endtask

  // wide value goes upper byte first, then lower
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    logic [DATA_W-1:0] q;
    access(1'b1, a, v[15:8], q);
    access(1'b1, a + 3'h1, v[7:0], q);
  endtask

  // flags clear only after they were seen set
  task automatic clear_flags();
    logic [DATA_W-1:0] q;
    access(1'b0, ADDR_FLAGS_CONTROL, 8'h00, q);
    access(1'b1, ADDR_FLAGS_CONTROL, 8'h00, q);
  endtask
endmodule

/* File: hold_latch.sv */
// byte-wide holding latch used for paired upper/lower transfers
`timescale 1ns/1ps
module hold_latch
  import timer_f_pkg::*;
(
  // clock and reset
  input  wire logic  mclk_in,
  input  wire logic  reset_in,
  // link to the register logic
  hold_link_if.latch link
);

  // ---------------------------------------------------------------
  // latch register
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] held_q;

  // only one producer a cycle: upper write data or lower counter snapshot
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      held_q <= ZERO_BYTE;
    end else if (link.load) begin
      held_q <= link.load_data;
    end
  end

  assign link.held = held_q;

endmodule

/* File: hold_link_if.sv */
// carrier between the register logic and the holding latch
`timescale 1ns/1ps
interface hold_link_if;
  import timer_f_pkg::*;

  logic              load;
  logic [DATA_W-1:0] load_data;
  logic [DATA_W-1:0] held;

  modport owner (output load, output load_data, input held);
  modport latch (input load, input load_data, output held);
endinterface

/* File: test_timer_f_status_and_cpu_port.sv */
// self-checking bench for the timer status and cpu port block
`timescale 1ns/1ps
module test_timer_f_status_and_cpu_port;
  import timer_f_pkg::*;
  logic              mclk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic              tick_lo = 1'b0;
  logic              tick_hi = 1'b0;
  wire [ADDR_W-1:0]  addr;
  wire               wr;
  wire               rd;
  wire [DATA_W-1:0]  wdata;
  logic [DATA_W-1:0] rdata;
  logic              irq_hi;
  logic              irq_lo;
  logic [15:0]       cnt;
  logic              split;
  logic              stby;
  logic [DATA_W-1:0] q;
  int                n_errors = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  always #5 mclk_in = ~mclk_in;

  cpu_bus_model cpu (.mclk_in(mclk_in), .bus_addr_out(addr), .bus_wr_out(wr), .bus_rd_out(rd),
    .bus_wdata_out(wdata), .bus_rdata_in(rdata));
  timer_f_status_and_cpu_port uut (.mclk_in(mclk_in), .reset_in(reset_in), .bus_addr_in(addr),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .count_lower_tick_in(tick_lo), .count_upper_tick_in(tick_hi),
    .upper_irq_request_flag_out(irq_hi), .lower_irq_request_flag_out(irq_lo),
    .counter_word_out(cnt), .split_mode_select_out(split), .module_standby_out(stby));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    cpu.access(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task wr8(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cpu.access(1'b1, a, d, q);
  endtask
  // one count pulse; a request pulse is looked at in the cycle after
  task tick(input logic lo, input logic hi);
    @(posedge mclk_in);
    tick_lo <= lo;
    tick_hi <= hi;
    @(posedge mclk_in);
    tick_lo <= 1'b0;
    tick_hi <= 1'b0;
    #1;
  endtask
  task wrap_up;
    $display("compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    chk(cnt, 16'h0000);
    rdc(ADDR_FLAGS_CONTROL, FLAGS_RESET);
    rdc(ADDR_COMPARE_UPPER, 8'hFF);
    rdc(ADDR_CLOCK_STOP, 8'hFF);
    rdc(ADDR_TIMER_CONTROL, UNMAPPED_READ);
    chk({15'h0, stby}, 16'h0000);
    $display("test reset done");
  endtask
  // snapshot must survive a count between the two reads
  task t_wide_access;
    wr8(ADDR_COUNTER_UPPER, 8'hAA);
    chk(cnt, 16'h0000);
    wr8(ADDR_COUNTER_LOWER, 8'h55);
    chk(cnt, 16'hAA55);
    rdc(ADDR_COUNTER_UPPER, 8'hAA);
    tick(1'b1, 1'b0);
    rdc(ADDR_COUNTER_LOWER, 8'h55);
    rdc(ADDR_COUNTER_UPPER, 8'hAA);
    rdc(ADDR_COUNTER_LOWER, 8'h56);
    cpu.wr16(ADDR_COMPARE_UPPER, 16'h1234);
    rdc(ADDR_COMPARE_LOWER, 8'h34);
    rdc(ADDR_COMPARE_UPPER, 8'h12);
    $display("test wide access done");
  endtask
  // overflow with the enable off, then on; flags cleared only after a read
  task t_overflow;
    for (int en = 0; en < 2; en++) begin
      cpu.wr16(ADDR_COUNTER_UPPER, 16'hFFFF);
      wr8(ADDR_FLAGS_CONTROL, (en == 1) ? 8'h20 : 8'h00);
      tick(1'b1, 1'b0);
      chk({15'h0, irq_hi}, en[15:0]);
      chk(cnt, 16'h0000);
      cpu.access(1'b0, ADDR_FLAGS_CONTROL, 8'h00, q);
      chk({8'h00, q & 8'hF0}, (en == 1) ? 16'h00A0 : 16'h0080);
      wr8(ADDR_FLAGS_CONTROL, 8'hFF);
      wr8(ADDR_FLAGS_CONTROL, 8'h00);
      cpu.access(1'b0, ADDR_FLAGS_CONTROL, 8'h00, q);
      chk({8'h00, q & 8'hF0}, 16'h0080);
      cpu.clear_flags();
      rdc(ADDR_FLAGS_CONTROL, 8'h00);
    end
    // full 16-bit match with the upper clear select clears the whole word
    cpu.wr16(ADDR_COUNTER_UPPER, 16'h1234);
    wr8(ADDR_FLAGS_CONTROL, 8'h10);
    tick(1'b1, 1'b0);
    chk({15'h0, irq_hi}, 16'h0001);
    chk({15'h0, irq_lo}, 16'h0000);
    chk(cnt, 16'h0000);
    rdc(ADDR_FLAGS_CONTROL, 8'h54);
    cpu.clear_flags();
    rdc(ADDR_FLAGS_CONTROL, 8'h00);
    $display("test overflow done");
  endtask
  task t_split;
    wr8(ADDR_TIMER_CONTROL, 8'h40);
    chk({15'h0, split}, 16'h0001);
    wr8(ADDR_COMPARE_LOWER, 8'h03);
    wr8(ADDR_FLAGS_CONTROL, 8'h03);
    wr8(ADDR_COUNTER_LOWER, 8'h03);
    wr8(ADDR_COUNTER_UPPER, 8'hFF);
    chk(cnt, 16'hFF03);
    tick(1'b1, 1'b0);
    chk({15'h0, irq_lo}, 16'h0001);
    chk(cnt, 16'hFF00);
    tick(1'b0, 1'b1);
    chk({15'h0, irq_hi}, 16'h0000);
    chk(cnt, 16'h0000);
    rdc(ADDR_FLAGS_CONTROL, 8'h87);
    wr8(ADDR_COUNTER_LOWER, 8'hFF);
    tick(1'b1, 1'b0);
    chk({15'h0, irq_lo}, 16'h0001);
    wr8(ADDR_COUNTER_UPPER, 8'h12);
    tick(1'b0, 1'b1);
    chk({15'h0, irq_hi}, 16'h0001);
    chk(cnt, 16'h1300);
    rdc(ADDR_FLAGS_CONTROL, 8'hCF);
    wr8(ADDR_FLAGS_CONTROL, 8'h10);
    wr8(ADDR_COUNTER_UPPER, 8'h12);
    tick(1'b0, 1'b1);
    chk(cnt, 16'h0000);
    $display("test split done");
  endtask
  task t_standby;
    wr8(ADDR_CLOCK_STOP, 8'hFB);
    chk({15'h0, stby}, 16'h0001);
    tick(1'b1, 1'b0);
    chk(cnt, 16'h0000);
    wr8(ADDR_CLOCK_STOP, 8'hFF);
    tick(1'b1, 1'b0);
    chk(cnt, 16'h0001);
    $display("test standby done");
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_wide_access();
    t_overflow();
    t_split();
    t_standby();
    wrap_up();
  end
endmodule

/* File: timer_f_chk.sv */
// port-level checks for the timer status and cpu port block
`timescale 1ns/1ps
module timer_f_chk
  import timer_f_pkg::*;
(
  // clock and reset
  input wire logic              mclk_in,
  input wire logic              reset_in,
  // bus and ticks
  input wire logic [ADDR_W-1:0] bus_addr_in,
  input wire logic              bus_wr_in,
  input wire logic              bus_rd_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic [DATA_W-1:0] bus_rdata_out,
  input wire logic              count_lower_tick_in,
  input wire logic              count_upper_tick_in,
  // outputs of the block
  input wire logic              upper_irq_request_flag_out,
  input wire logic              lower_irq_request_flag_out,
  input wire logic [15:0]       counter_word_out,
  input wire logic              split_mode_select_out,
  input wire logic              module_standby_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  AST_STANDBY_HOLDS: assert property (module_standby_out && !bus_wr_in
    |=> $stable(counter_word_out))
    else $error("counter moved while halted");
  AST_WIDE_COUNT: assert property (!split_mode_select_out && !module_standby_out
    && count_lower_tick_in && !bus_wr_in
    |=> counter_word_out == $past(counter_word_out) + 16'h0001
        || counter_word_out == 16'h0000)
    else $error("wide counter did not step by one");
  AST_IRQ_CAUSE: assert property (upper_irq_request_flag_out
    |-> $past(count_lower_tick_in || count_upper_tick_in) && !$past(module_standby_out))
    else $error("upper request without a count event");

  // ---------------------------------------------------------------
  // cpu port
  // ---------------------------------------------------------------
  AST_RDATA_HOLD: assert property (!bus_rd_in |=> $stable(bus_rdata_out))
    else $error("read data changed without a read");
  AST_SPLIT_SEL: assert property (bus_wr_in && bus_addr_in == ADDR_TIMER_CONTROL
    |=> split_mode_select_out == $past(bus_wdata_in[BIT_SPLIT_MODE_SELECT]))
    else $error("split select not taken from write");
  AST_RUN_BIT: assert property (bus_wr_in && bus_addr_in == ADDR_CLOCK_STOP
    |=> module_standby_out != $past(bus_wdata_in[BIT_TIMER_MODULE_RUN]))
    else $error("standby does not follow run bit");
  AST_LOWER_WRITE: assert property (bus_wr_in && bus_addr_in == ADDR_COUNTER_LOWER
    |=> counter_word_out[7:0] == $past(bus_wdata_in))
    else $error("lower counter write lost");
  AST_UPPER_LATCH_ONLY: assert property (!split_mode_select_out && bus_wr_in
    && bus_addr_in == ADDR_COUNTER_UPPER && !count_lower_tick_in
    |=> $stable(counter_word_out))
    else $error("wide upper write changed counter");
  AST_UPPER_READ: assert property (bus_rd_in && bus_addr_in == ADDR_COUNTER_UPPER
    |=> bus_rdata_out == $past(counter_word_out[15:8]))
    else $error("upper counter read wrong");
  AST_LATCHED_LOWER: assert property (!split_mode_select_out
    && bus_rd_in && bus_addr_in == ADDR_COUNTER_UPPER ##1 !bus_rd_in
    ##1 bus_rd_in && bus_addr_in == ADDR_COUNTER_LOWER
    |=> bus_rdata_out == $past(counter_word_out[7:0], 3))
    else $error("lower read not the snapshot");
endmodule

bind timer_f_status_and_cpu_port timer_f_chk chk (.mclk_in, .reset_in, .bus_addr_in, .bus_wr_in,
  .bus_rd_in, .bus_wdata_in, .bus_rdata_out, .count_lower_tick_in, .count_upper_tick_in,
  .upper_irq_request_flag_out, .lower_irq_request_flag_out, .counter_word_out,
  .split_mode_select_out, .module_standby_out);

/* File: timer_f_pkg.sv */
// constants shared by the timer status block and its holding latch
package timer_f_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // ---------------------------------------------------------------
  // register offsets on the 8-bit peripheral bus
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_TIMER_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_CONTROL = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER_UPPER = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER_LOWER = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_UPPER = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_LOWER = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_STOP    = 3'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_UPPER_OVERFLOW_FLAG = 7;
  localparam int BIT_UPPER_MATCH_FLAG    = 6;
  localparam int BIT_UPPER_OVERFLOW_IRQE = 5;
  localparam int BIT_UPPER_CLEAR_MATCH   = 4;
  localparam int BIT_LOWER_OVERFLOW_FLAG = 3;
  localparam int BIT_LOWER_MATCH_FLAG    = 2;
  localparam int BIT_LOWER_OVERFLOW_IRQE = 1;
  localparam int BIT_LOWER_CLEAR_MATCH   = 0;
  localparam int BIT_SPLIT_MODE_SELECT   = 6;
  localparam int BIT_TIMER_MODULE_RUN    = 2;

  // ---------------------------------------------------------------
  // masks and reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] FLAG_BITS_MASK    = 8'hCC;
  localparam logic [DATA_W-1:0] CONTROL_BITS_MASK = 8'h33;
  localparam logic [DATA_W-1:0] FLAGS_RESET       = 8'h00;
  localparam logic [DATA_W-1:0] TIMER_CTRL_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] CLOCK_STOP_RESET  = 8'hFF;
  localparam logic [DATA_W-1:0] COUNTER_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] COMPARE_RESET     = 8'hFF;
  localparam logic [DATA_W-1:0] HALF_ALL_ONES     = 8'hFF;
  localparam logic [DATA_W-1:0] HALF_ONE          = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE         = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ     = 8'hFF;

endpackage

/* File: timer_f_status_and_cpu_port.sv */
// status, control and 8-bit cpu port logic of the split-capable 16-bit timer
`timescale 1ns/1ps
module timer_f_status_and_cpu_port
  import timer_f_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  // 8-bit peripheral bus
  input  wire logic [ADDR_W-1:0] bus_addr_in,
  input  wire logic              bus_wr_in,
  input  wire logic              bus_rd_in,
  input  wire logic [DATA_W-1:0] bus_wdata_in,
  output logic      [DATA_W-1:0] bus_rdata_out,
  // count enables from the clock select logic, same clock
  input  wire logic              count_lower_tick_in,
  input  wire logic              count_upper_tick_in,
  // interrupt requests to the interrupt controller
  output logic                   upper_irq_request_flag_out,
  output logic                   lower_irq_request_flag_out,
  // state visible to neighbouring logic
  output logic      [15:0]       counter_word_out,
  output logic                   split_mode_select_out,
  output logic                   module_standby_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hits(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] target);
    hits = (a == target);
  endfunction

  wire wr_timer_ctrl = bus_wr_in & hits(bus_addr_in, ADDR_TIMER_CONTROL);
  wire wr_flags      = bus_wr_in & hits(bus_addr_in, ADDR_FLAGS_CONTROL);
  wire wr_cnt_hi     = bus_wr_in & hits(bus_addr_in, ADDR_COUNTER_UPPER);
  wire wr_cnt_lo     = bus_wr_in & hits(bus_addr_in, ADDR_COUNTER_LOWER);
  wire wr_cmp_hi     = bus_wr_in & hits(bus_addr_in, ADDR_COMPARE_UPPER);
  wire wr_cmp_lo     = bus_wr_in & hits(bus_addr_in, ADDR_COMPARE_LOWER);
  wire wr_clk_stop   = bus_wr_in & hits(bus_addr_in, ADDR_CLOCK_STOP);
  wire rd_flags      = bus_rd_in & hits(bus_addr_in, ADDR_FLAGS_CONTROL);
  wire rd_cnt_hi     = bus_rd_in & hits(bus_addr_in, ADDR_COUNTER_UPPER);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] timer_control_reg_q;
  logic [DATA_W-1:0] timer_flags_and_control_q;
  logic [DATA_W-1:0] timer_flags_and_control_d;
  logic [DATA_W-1:0] peripheral_clock_stop_one_q;
  logic [DATA_W-1:0] read_armed_q;
  logic [DATA_W-1:0] read_armed_d;
  logic [DATA_W-1:0] counter_upper_half_q;
  logic [DATA_W-1:0] counter_upper_half_d;
  logic [DATA_W-1:0] counter_lower_half_q;
  logic [DATA_W-1:0] counter_lower_half_d;
  logic [DATA_W-1:0] compare_upper_half_q;
  logic [DATA_W-1:0] compare_upper_half_d;
  logic [DATA_W-1:0] compare_lower_half_q;
  logic [DATA_W-1:0] compare_lower_half_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              upper_irq_q;
  logic              lower_irq_q;
  logic              standby_q;

  // ---------------------------------------------------------------
  // holding latch shared by all paired transfers
  // ---------------------------------------------------------------
  // one latch serves counter writes, compare writes and counter reads,
  // so two pairs interleaved corrupt each other; software must keep
  // each upper/lower pair together, the latch cannot tell them apart
  hold_link_if hold ();

  hold_latch u_hold_latch (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .link     (hold.latch)
  );

  // ---------------------------------------------------------------
  // mode and control fields
  // ---------------------------------------------------------------
  wire split_mode      = timer_control_reg_q[BIT_SPLIT_MODE_SELECT];
  wire timer_run       = peripheral_clock_stop_one_q[BIT_TIMER_MODULE_RUN];
  wire upper_ovf_irqe  = timer_flags_and_control_q[BIT_UPPER_OVERFLOW_IRQE];
  wire upper_clear_sel = timer_flags_and_control_q[BIT_UPPER_CLEAR_MATCH];
  wire lower_ovf_irqe  = timer_flags_and_control_q[BIT_LOWER_OVERFLOW_IRQE];
  wire lower_clear_sel = timer_flags_and_control_q[BIT_LOWER_CLEAR_MATCH];

  // ---------------------------------------------------------------
  // counting events
  // ---------------------------------------------------------------
  // the match event fires on the tick that leaves the matching value,
  // so a freshly written equal value is seen on the next count pulse
  wire tick_lo    = timer_run & count_lower_tick_in;
  wire lo_equal   = (counter_lower_half_q == compare_lower_half_q);
  wire hi_equal   = (counter_upper_half_q == compare_upper_half_q);
  wire lo_at_top  = (counter_lower_half_q == HALF_ALL_ONES);
  wire hi_at_top  = (counter_upper_half_q == HALF_ALL_ONES);
  // a write landing on the same edge swallows the overflow
  wire lo_ovf     = tick_lo & lo_at_top & ~wr_cnt_lo;
  wire tick_hi    = split_mode ? (timer_run & count_upper_tick_in)
                               : (tick_lo & lo_at_top);
  wire hi_ovf     = tick_hi & hi_at_top & ~(split_mode ? wr_cnt_hi : wr_cnt_lo);
  wire lo_match   = tick_lo & lo_equal & ~wr_cmp_lo;
  wire hi_match   = split_mode ? (tick_hi & hi_equal & ~wr_cmp_hi)
                               : (tick_lo & lo_equal & hi_equal & ~wr_cmp_lo);
  // clear selects: upper one clears the whole word in wide mode, each its own half in split mode
  wire clear_hi   = upper_clear_sel & hi_match;
  wire clear_lo   = (split_mode & lower_clear_sel & lo_match)
                  | (~split_mode & clear_hi);

  // ---------------------------------------------------------------
  // paired transfer steering
  // ---------------------------------------------------------------
  // wide mode: upper writes park in the latch, lower writes commit both
  wire pair_cnt_commit = wr_cnt_lo & ~split_mode;
  wire pair_cmp_commit = wr_cmp_lo & ~split_mode;
  wire direct_cnt_hi   = wr_cnt_hi & split_mode;
  wire direct_cmp_hi   = wr_cmp_hi & split_mode;
  wire park_upper      = (wr_cnt_hi | wr_cmp_hi) & ~split_mode;
  wire snap_lower      = rd_cnt_hi & ~split_mode;

  assign hold.load      = park_upper | snap_lower;
  assign hold.load_data = park_upper ? bus_wdata_in : counter_lower_half_q;

  // ---------------------------------------------------------------
  // counter next values
  // ---------------------------------------------------------------
  // cpu write beats clear, clear beats increment
  always_comb begin
    counter_upper_half_d = counter_upper_half_q;
    if (direct_cnt_hi) begin
      counter_upper_half_d = bus_wdata_in;
    end else if (pair_cnt_commit) begin
      counter_upper_half_d = hold.held;
    end else if (clear_hi) begin
      counter_upper_half_d = ZERO_BYTE;
    end else if (tick_hi) begin
      counter_upper_half_d = counter_upper_half_q + HALF_ONE;
    end
  end

  always_comb begin
    counter_lower_half_d = counter_lower_half_q;
    if (wr_cnt_lo) begin
      counter_lower_half_d = bus_wdata_in;
    end else if (clear_lo) begin
      counter_lower_half_d = ZERO_BYTE;
    end else if (tick_lo) begin
      counter_lower_half_d = counter_lower_half_q + HALF_ONE;
    end
  end

  // compare halves never count; only the cpu changes them
  assign compare_upper_half_d = direct_cmp_hi   ? bus_wdata_in :
                                pair_cmp_commit ? hold.held    : compare_upper_half_q;
  assign compare_lower_half_d = wr_cmp_lo ? bus_wdata_in : compare_lower_half_q;

  // ---------------------------------------------------------------
  // flags: set by hardware, cleared by read-one then write-zero
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] flag_set_v =
    (DATA_W'(hi_ovf)   << BIT_UPPER_OVERFLOW_FLAG) |
    (DATA_W'(hi_match) << BIT_UPPER_MATCH_FLAG)    |
    (DATA_W'(lo_ovf)   << BIT_LOWER_OVERFLOW_FLAG) |
    (DATA_W'(lo_match) << BIT_LOWER_MATCH_FLAG);

  // a zero only clears a flag that the last flags read saw as one
  wire [DATA_W-1:0] flag_clear_v =
    {DATA_W{wr_flags}} & ~bus_wdata_in & read_armed_q & FLAG_BITS_MASK;

  // ones written to flag positions are dropped by the mask
  wire [DATA_W-1:0] ctrl_new  = bus_wdata_in & CONTROL_BITS_MASK;
  wire [DATA_W-1:0] ctrl_keep = timer_flags_and_control_q & CONTROL_BITS_MASK;
  wire [DATA_W-1:0] ctrl_part = wr_flags ? ctrl_new : ctrl_keep;

  // set is or-ed last so a coincident event survives the clear
  assign timer_flags_and_control_d =
    ctrl_part | (timer_flags_and_control_q & FLAG_BITS_MASK & ~flag_clear_v)
              | flag_set_v;

  // arming is refreshed by each flags read and spent by each flags write
  assign read_armed_d = rd_flags ? (timer_flags_and_control_q & FLAG_BITS_MASK) :
                        wr_flags ? ZERO_BYTE : read_armed_q;

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (bus_rd_in) begin
      case (bus_addr_in)
        ADDR_FLAGS_CONTROL: rdata_d = timer_flags_and_control_q;
        ADDR_COUNTER_UPPER: rdata_d = counter_upper_half_q;
        ADDR_COUNTER_LOWER: rdata_d = split_mode ? counter_lower_half_q
                                                 : hold.held;
        ADDR_COMPARE_UPPER: rdata_d = compare_upper_half_q;
        ADDR_COMPARE_LOWER: rdata_d = compare_lower_half_q;
        ADDR_CLOCK_STOP:    rdata_d = peripheral_clock_stop_one_q;
        default:            rdata_d = UNMAPPED_READ; // control reg is write-only
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      timer_flags_and_control_q <= FLAGS_RESET;
      read_armed_q              <= ZERO_BYTE;
      timer_control_reg_q       <= TIMER_CTRL_RESET;
      peripheral_clock_stop_one_q <= CLOCK_STOP_RESET;
    end else begin
      timer_flags_and_control_q <= timer_flags_and_control_d;
      read_armed_q              <= read_armed_d;
      if (wr_timer_ctrl) begin
        timer_control_reg_q <= bus_wdata_in;
      end
      if (wr_clk_stop) begin
        peripheral_clock_stop_one_q <= bus_wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      counter_upper_half_q <= COUNTER_RESET;
      counter_lower_half_q <= COUNTER_RESET;
      compare_upper_half_q <= COMPARE_RESET;
      compare_lower_half_q <= COMPARE_RESET;
    end else begin
      counter_upper_half_q <= counter_upper_half_d;
      counter_lower_half_q <= counter_lower_half_d;
      compare_upper_half_q <= compare_upper_half_d;
      compare_lower_half_q <= compare_lower_half_d;
    end
  end

  // standby kept in a flop of its own so the output needs no inverter
  // behind the register; it is written on the same edge as the run bit,
  // so the two never disagree, at the cost of one extra flip-flop
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      standby_q <= ~CLOCK_STOP_RESET[BIT_TIMER_MODULE_RUN];
    end else if (wr_clk_stop) begin
      standby_q <= ~bus_wdata_in[BIT_TIMER_MODULE_RUN];
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests and bus answer
  // ---------------------------------------------------------------
  // lower half raises its own request only when the halves run apart
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      upper_irq_q <= 1'b0;
      lower_irq_q <= 1'b0;
      rdata_q     <= ZERO_BYTE;
    end else begin
      upper_irq_q <= (hi_ovf & upper_ovf_irqe) | hi_match;
      lower_irq_q <= split_mode & ((lo_ovf & lower_ovf_irqe) | lo_match);
      rdata_q     <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign bus_rdata_out              = rdata_q;
  assign upper_irq_request_flag_out = upper_irq_q;
  assign lower_irq_request_flag_out = lower_irq_q;
  assign counter_word_out           = {counter_upper_half_q, counter_lower_half_q};
  assign split_mode_select_out      = timer_control_reg_q[BIT_SPLIT_MODE_SELECT];
  assign module_standby_out         = standby_q;

endmodule
